// >>> core/conversion_start_bit_pkg.sv
package conversion_start_bit_pkg;
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_MASK     = 8'h08;
  localparam logic [7:0] ADDR_RES_LOW  = 8'h0c;
  localparam logic [7:0] ADDR_RES_HIGH = 8'h10;

  localparam int CTRL_EN    = 7;
  localparam int CTRL_START = 6;
  localparam int CTRL_ATE   = 5;
  localparam int CTRL_DIFF  = 4;
  localparam int CTRL_LEFT  = 3;
  localparam int CTRL_PS_LO = 0;
  localparam int ST_DONE    = 0;
  localparam int ST_SLEEP   = 1;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] MASK_RESET = 2'h0;

  // Half converter clock periods: 15.5 and 25 cycles
  localparam logic [5:0] HALF_NORMAL   = 6'h1f;
  localparam logic [5:0] HALF_FIRST    = 6'h32;
  // Sample and hold at 3.5 and 13.5 cycles
  localparam logic [5:0] SAMPLE_NORMAL = 6'h07;
  localparam logic [5:0] SAMPLE_FIRST  = 6'h1b;

  localparam logic [2:0] SLP_IDLE  = 3'h0;
  localparam logic [2:0] SLP_NOISE = 3'h1;

  localparam logic [9:0] SE_MAX   = 10'h3ff;
  localparam logic [9:0] SE_MIN   = 10'h000;
  localparam logic [9:0] DIFF_MAX = 10'h1ff;
  localparam logic [9:0] DIFF_MIN = 10'h200;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_CONV = 3'b100
  } conversion_start_bit_state_t;
endpackage

// >>> core/conversion_start_bit_prescaler.sv
`timescale 1ns/1ns
module conversion_start_bit_prescaler
  import conversion_start_bit_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       enable,
  input  wire logic [2:0] sel,
  output logic            half_tick,
  output logic            rise
);
  typedef struct packed {
    logic [6:0] cnt;
    logic       phase;
  } conversion_start_bit_pre_t;

  conversion_start_bit_pre_t r;
  conversion_start_bit_pre_t next_r;
  logic [6:0] mask;

  function automatic logic [6:0] half_mask(input logic [2:0] s);
    logic [6:0] m;
    m = 7'h00;
    if (s > 3'h1) begin
      m = 7'((8'h1 << (s - 3'h1)) - 8'h1);
    end
    return m;
  endfunction

  always_comb begin
    next_r    = r;
    mask      = half_mask(sel);
    half_tick = enable && ((r.cnt & mask) == mask);
    rise      = half_tick && !r.phase;
    // Held in reset while the converter is off
    if (!enable) begin
      next_r = '0;
    end else begin
      next_r.cnt = r.cnt + 7'h01;
      if (half_tick) begin
        next_r.phase = !r.phase;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

// >>> core/conversion_start_bit_format.sv
`timescale 1ns/1ns
module conversion_start_bit_format
  import conversion_start_bit_pkg::*;
(
  input  wire logic signed [11:0] sample,
  input  wire logic               diff,
  input  wire logic        [9:0]  code,
  input  wire logic               left,
  output logic             [9:0]  new_code,
  output logic             [7:0]  res_low,
  output logic             [7:0]  res_high
);
  always_comb begin
    if (diff) begin
      // Two's complement, saturating at both ends
      if (sample > 12'sh1ff) begin
        new_code = DIFF_MAX;
      end else if (sample < -12'sh200) begin
        new_code = DIFF_MIN;
      end else begin
        new_code = sample[9:0];
      end
    end else if (sample < 12'sh000) begin
      new_code = SE_MIN;
    end else if (sample > 12'sh3ff) begin
      new_code = SE_MAX;
    end else begin
      new_code = sample[9:0];
    end
  end

  // Alignment follows the control live, even mid conversion
  always_comb begin
    if (left) begin
      res_high = code[9:2];
      res_low  = {code[1:0], 6'h00};
    end else begin
      res_high = {6'h00, code[9:8]};
      res_low  = code[7:0];
    end
  end
endmodule

// >>> core/conversion_start_bit_core.sv
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ns
module conversion_start_bit_core
  import conversion_start_bit_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cpu_halted,
  input  wire logic [2:0]  sleep_mode,
  input  wire logic [11:0] ain_value,
  input  wire logic        trig_in,
  output logic             irq,
  output logic             conv_busy,
  output logic             converter_on
);
  typedef struct packed {
    conversion_start_bit_state_t state;
    logic [5:0]  half;
    logic        first_pend;
    logic        first_run;
    logic        sleep_run;
    logic [7:0]  ctrl;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [9:0]  code;
    logic [11:0] ain_s1;
    logic [11:0] ain_s2;
    logic [11:0] sample;
    logic        trig_s1;
    logic        trig_s2;
    logic        trig_d;
    logic        halt_d;
    logic [31:0] rdata;
    logic [4:0]  rises;
  } conversion_start_bit_regs_t;

  conversion_start_bit_regs_t r;
  conversion_start_bit_regs_t next_r;

  logic       half_tick;
  logic       rise;
  logic [9:0] new_code;
  logic [7:0] res_low;
  logic [7:0] res_high;
  logic       en;
  logic       wr;
  logic       rd_setup;
  logic       mapped;
  logic       sleep_go;
  logic       trig_go;
  logic       conv_end;
  logic [5:0] half_n;

  function automatic logic is_reg(input logic [7:0] a,
                                  input logic [7:0] b);
    return a == b;
  endfunction

  conversion_start_bit_prescaler u_pre (
    .clk       (clk),
    .nrst      (nrst),
    .enable    (r.ctrl[CTRL_EN]),
    .sel       (r.ctrl[CTRL_PS_LO+:3]),
    .half_tick (half_tick),
    .rise      (rise)
  );

  conversion_start_bit_format u_fmt (
    .sample   (r.sample),
    .diff     (r.ctrl[CTRL_DIFF]),
    .code     (r.code),
    .left     (r.ctrl[CTRL_LEFT]),
    .new_code (new_code),
    .res_low  (res_low),
    .res_high (res_high)
  );

  always_comb begin
    if (is_reg(paddr, ADDR_CTRL)) begin
      mapped = 1'b1;
    end else if (is_reg(paddr, ADDR_STATUS)) begin
      mapped = 1'b1;
    end else if (is_reg(paddr, ADDR_MASK)) begin
      mapped = 1'b1;
    end else if (is_reg(paddr, ADDR_RES_LOW)) begin
      mapped = 1'b1;
    end else if (is_reg(paddr, ADDR_RES_HIGH)) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  assign pready       = 1'b1;
  assign pslverr      = psel && penable && !mapped;
  assign prdata       = r.rdata;
  assign irq          = |(r.status & r.mask);
  assign conv_busy    = r.ctrl[CTRL_START];
  assign converter_on = r.ctrl[CTRL_EN];

  always_comb begin
    next_r   = r;
    en       = r.ctrl[CTRL_EN];
    wr       = psel && penable && pwrite && mapped;
    rd_setup = psel && !penable && !pwrite;
    conv_end = 1'b0;
    half_n   = r.half + 6'h01;

    // Pins are resynchronised; the bus value is only sampled
    // long after it settles, so per-bit skew does no harm
    next_r.ain_s1  = ain_value;
    next_r.ain_s2  = r.ain_s1;
    next_r.trig_s1 = trig_in;
    next_r.trig_s2 = r.trig_s1;
    next_r.trig_d  = r.trig_s2;
    next_r.halt_d  = cpu_halted;

    // Only a fresh halt in a quiet mode starts a sleep conversion
    sleep_go = cpu_halted && !r.halt_d && en
               && (sleep_mode == SLP_IDLE || sleep_mode == SLP_NOISE)
               && !r.ctrl[CTRL_ATE] && !r.ctrl[CTRL_START]
               && r.state == ST_IDLE;
    trig_go  = r.ctrl[CTRL_ATE] && r.trig_s2 && !r.trig_d && en
               && r.state == ST_IDLE && !r.ctrl[CTRL_START];

    if (rd_setup) begin
      if (is_reg(paddr, ADDR_CTRL)) begin
        next_r.rdata = {24'h000000, r.ctrl};
      end else if (is_reg(paddr, ADDR_STATUS)) begin
        next_r.rdata = {30'h00000000, r.status};
      end else if (is_reg(paddr, ADDR_MASK)) begin
        next_r.rdata = {30'h00000000, r.mask};
      end else if (is_reg(paddr, ADDR_RES_LOW)) begin
        next_r.rdata = {24'h000000, res_low};
      end else if (is_reg(paddr, ADDR_RES_HIGH)) begin
        next_r.rdata = {24'h000000, res_high};
      end else begin
        next_r.rdata = 32'h00000000;
      end
    end

    if (wr && is_reg(paddr, ADDR_CTRL)) begin
      next_r.ctrl = pwdata[7:0];
      next_r.ctrl[CTRL_START] = r.ctrl[CTRL_START];
      if (!r.ctrl[CTRL_EN] && pwdata[CTRL_EN]) begin
        next_r.first_pend = 1'b1;
      end
    end
    if (wr && is_reg(paddr, ADDR_STATUS)) begin
      next_r.status = r.status & ~pwdata[1:0];
    end
    if (wr && is_reg(paddr, ADDR_MASK)) begin
      next_r.mask = pwdata[1:0];
    end

    case (r.state)
      ST_IDLE: begin
        if (r.ctrl[CTRL_START] && en) begin
          next_r.state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Starts on the next rising converter clock edge
        if (rise) begin
          next_r.state      = ST_CONV;
          next_r.half       = 6'h00;
          next_r.rises      = 5'h00;
          next_r.first_run  = r.first_pend;
          next_r.first_pend = 1'b0;
        end
      end
      ST_CONV: begin
        if (rise) begin
          next_r.rises = r.rises + 5'h01;
        end
        if (half_tick) begin
          next_r.half = half_n;
          if (half_n == (r.first_run ? SAMPLE_FIRST
                                     : SAMPLE_NORMAL)) begin
            next_r.sample = r.ain_s2;
          end
          if (half_n == (r.first_run ? HALF_FIRST
                                     : HALF_NORMAL)) begin
            conv_end                = 1'b1;
            next_r.state            = ST_IDLE;
            next_r.code             = new_code;
            next_r.status[ST_DONE]  = 1'b1;
            next_r.ctrl[CTRL_START] = 1'b0;
            next_r.sleep_run        = 1'b0;
            if (r.sleep_run) begin
              next_r.status[ST_SLEEP] = 1'b1;
            end
          end
        end
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase

    // Late so that a new start wins over the completion clear
    if (wr && is_reg(paddr, ADDR_CTRL) && pwdata[CTRL_START]) begin
      next_r.ctrl[CTRL_START] = 1'b1;
    end
    if (sleep_go || trig_go) begin
      next_r.ctrl[CTRL_START] = 1'b1;
      next_r.sleep_run        = sleep_go;
    end

    // Switching off aborts any conversion in flight
    if (!next_r.ctrl[CTRL_EN]) begin
      next_r.state            = ST_IDLE;
      next_r.ctrl[CTRL_START] = 1'b0;
      next_r.sleep_run        = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r       <= '0;
      r.state <= ST_IDLE;
      r.ctrl  <= CTRL_RESET;
      r.mask  <= MASK_RESET;
    end else begin
      r <= next_r;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_sleep_start;
    sleep_go ##1 r.ctrl[CTRL_START];
  endsequence

  sequence s_done_set;
    conv_end ##1 (r.status[ST_DONE] && r.code == $past(new_code));
  endsequence

  sleep_conv_start_a: assert property (
    sleep_go |-> s_sleep_start ##1 (r.state == ST_WAIT || !en)
  ) else $error("sleep entry did not start a conversion");

  single_sleep_a: assert property (
    sleep_go |=> !sleep_go throughout ##[1:2] 1'b1
  ) else $error("second sleep conversion without new sleep");

  done_and_result_a: assert property (
    conv_end && en |-> s_done_set
  ) else $error("result and done flag not written together");

  start_cleared_a: assert property (
    conv_end && !(wr && pwdata[CTRL_START])
    |=> !r.ctrl[CTRL_START] && r.state == ST_IDLE
  ) else $error("start bit not cleared at completion");

  done_irq_a: assert property (
    r.status[ST_DONE] && r.mask[ST_DONE] |-> irq
  ) else $error("done flag unmasked but no interrupt");

  conv_length_a: assert property (
    conv_end |-> r.rises == (r.first_run ? 5'h18 : 5'h0f)
  ) else $error("conversion length wrong");

  enable_kept_a: assert property (
    $fell(r.ctrl[CTRL_EN]) |-> $past(wr) && $past(paddr) == ADDR_CTRL
  ) else $error("converter switched off by hardware");

  left_align_a: assert property (
    r.ctrl[CTRL_LEFT] |-> res_high == r.code[9:2]
                          && res_low[7:6] == r.code[1:0]
  ) else $error("left aligned bytes wrong");

  right_align_a: assert property (
    !r.ctrl[CTRL_LEFT] |-> res_high[7:2] == 6'h00
                           && res_low == r.code[7:0]
  ) else $error("right aligned bytes wrong");

  diff_sign_a: assert property (
    r.ctrl[CTRL_DIFF] |-> new_code[9] == r.sample[11]
  ) else $error("differential sign bit wrong");

  diff_sat_a: assert property (
    r.ctrl[CTRL_DIFF] && $signed(r.sample) > 12'sh1ff
    |-> new_code == DIFF_MAX
  ) else $error("differential overrange not saturated");

  single_clamp_a: assert property (
    !r.ctrl[CTRL_DIFF] && r.sample[11] |-> new_code == SE_MIN
  ) else $error("negative single ended input not zero");

  sequence s_sleep_flag;
    (conv_end && r.sleep_run) ##1 r.status[ST_SLEEP];
  endsequence

  sequence s_done_irq;
    conv_end ##1 (r.status[ST_DONE] && irq);
  endsequence

  sleep_flag_a: assert property (
    conv_end && r.sleep_run |-> s_sleep_flag
  ) else $error("sleep conversion not flagged");

  wake_irq_a: assert property (
    conv_end && r.mask[ST_DONE] && !wr |-> s_done_irq
  ) else $error("completion did not raise the interrupt");

  done_set_wins_a: assert property (
    conv_end && wr && paddr == ADDR_STATUS && pwdata[ST_DONE]
    |=> r.status[ST_DONE]
  ) else $error("completion lost to a same cycle clear");

  halt_edge_only_a: assert property (
    sleep_go |-> $rose(cpu_halted)
  ) else $error("sleep conversion without a fresh halt");

  first_armed_a: assert property (
    $rose(en) |-> r.first_pend
  ) else $error("enabling did not arm a long first conversion");

  conv_on_edge_a: assert property (
    $rose(r.state == ST_CONV) |-> $past(rise)
  ) else $error("conversion began off a converter clock edge");
endmodule

// >>> sim/conversion_start_bit_cpu_model.sv
`timescale 1ns/1ns
module conversion_start_bit_cpu_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       sleep_cmd,
  input  wire logic [2:0] mode_cmd,
  input  wire logic       other_wake,
  input  wire logic       irq,
  output logic            cpu_halted,
  output logic      [2:0] sleep_mode,
  output logic            woke_on_irq
);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cpu_halted  <= 1'b0;
      sleep_mode  <= 3'h7;
      woke_on_irq <= 1'b0;
    end else if (!cpu_halted) begin
      // Mode means nothing while awake, so it wanders
      sleep_mode <= sleep_cmd ? mode_cmd : ~sleep_mode;
      cpu_halted <= sleep_cmd;
    end else if (irq || other_wake) begin
      cpu_halted  <= 1'b0;
      woke_on_irq <= irq;
    end
  end
endmodule

// >>> sim/adc_sleep_conversion_and_result_coding_tb.sv
`timescale 1ns/1ns
module adc_sleep_conversion_and_result_coding_tb import conversion_start_bit_pkg::*;;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rdata;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        irq;
  logic        conv_busy;
  logic        converter_on;
  logic        cpu_halted;
  logic        woke;
  logic [2:0]  sleep_mode;
  logic [2:0]  mode_cmd = 3'h0;
  logic        sleep_cmd = 1'b0;
  logic        other_wake = 1'b0;
  logic        trig = 1'b0;
  logic [11:0] ain = 12'h000;
  logic [31:0] seed = 32'h3fb5111e;
  int          miscompares = 0;
  int          n_compared = 0;
  int          n;
  logic [11:0] tbl [10] = '{12'h000, 12'hfff, 12'h7ff, 12'h800, 12'h1ff,
                            12'h200, 12'h3ff, 12'h400, 12'he00, 12'hdff};

  always #2 clk = ~clk;

  conversion_start_bit_core u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_halted(cpu_halted),
    .sleep_mode(sleep_mode), .ain_value(ain), .trig_in(trig), .irq(irq),
    .conv_busy(conv_busy), .converter_on(converter_on));

  conversion_start_bit_cpu_model u_cpu (.clk(clk), .nrst(nrst), .sleep_cmd(sleep_cmd),
    .mode_cmd(mode_cmd), .other_wake(other_wake), .irq(irq),
    .cpu_halted(cpu_halted), .sleep_mode(sleep_mode), .woke_on_irq(woke));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] exp_pair(input logic [11:0] s,
                                           input bit d, input bit l);
    int         v;
    logic [9:0] c;
    v = int'($signed(s));
    if (d) v = v < -512 ? -512 : (v > 511 ? 511 : v);
    else v = v < 0 ? 0 : (v > 1023 ? 1023 : v);
    c = 10'(v);
    return l ? {c[9:2], c[1:0], 6'h00} : {6'h00, c};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h..%h", $time, got,
               lo, hi);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bounded so a dead design cannot hang the wait
  task automatic wait_lvl(ref logic s, input logic v, output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (s !== v && k < 3000);
    if (s !== v) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, s, v);
    end
  endtask

  task automatic go_sleep(input logic [2:0] m);
    @(posedge clk);
    sleep_cmd <= 1'b1;
    mode_cmd <= m;
    @(posedge clk);
    sleep_cmd <= 1'b0;
  endtask

  task automatic wake_other();
    @(posedge clk);
    other_wake <= 1'b1;
    @(posedge clk);
    other_wake <= 1'b0;
  endtask

  task automatic conv(input logic [11:0] s, input bit d, input bit l,
                      input int h);
    logic [1:0]  ps;
    int          f;
    int          k;
    logic [15:0] e;
    ps = 2'(rnd());
    f = (ps < 2) ? 1 : (1 << (ps - 1));
    e = exp_pair(s, d, l);
    @(posedge clk);
    ain <= s;
    apb(1'b1, ADDR_CTRL, {24'h0, 3'b110, d, l, 1'b0, ps});
    wait_lvl(irq, 1'b1, k);
    chk_rng(k, h * f, (h + 4) * f + 4);
    apb(1'b0, ADDR_RES_LOW, 32'h0);
    chk(rdata, {24'h0, e[7:0]});
    apb(1'b0, ADDR_RES_HIGH, 32'h0);
    chk(rdata, {24'h0, e[15:8]});
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rdata & 32'h40, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdata, 32'h1);
    // Alignment must follow the control at once, no new conversion
    e = exp_pair(s, d, ~l);
    apb(1'b1, ADDR_CTRL, {24'h0, 3'b100, d, ~l, 1'b0, ps});
    apb(1'b0, ADDR_RES_HIGH, 32'h0);
    chk(rdata, {24'h0, e[15:8]});
    apb(1'b1, ADDR_STATUS, 32'h1);
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end

  initial begin
    logic [11:0] s;
    logic [15:0] e;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rdata, {24'h0, CTRL_RESET});
    apb(1'b0, ADDR_MASK, 32'h0);
    chk(rdata, {30'h0, MASK_RESET});
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, ADDR_MASK, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h80);
    conv(12'h1f4, 1'b0, 1'b0, 50);
    for (int i = 0; i < 16; i++) begin
      s = i < 10 ? tbl[i] : 12'(rnd());
      conv(s, 1'b0, 1'(rnd()), 31);
      conv(s, 1'b1, 1'(rnd()), 31);
    end
    apb(1'b1, ADDR_CTRL, 32'h80);
    apb(1'b1, ADDR_MASK, 32'h3);
    for (int m = 1; m >= 0; m--) begin
      s = 12'(rnd());
      e = exp_pair(s, 1'b0, 1'b0);
      @(posedge clk);
      ain <= s;
      go_sleep(3'(m));
      wait_lvl(cpu_halted, 1'b0, n);
      chk({31'h0, woke}, 32'h1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rdata, 32'h3);
      apb(1'b0, ADDR_RES_LOW, 32'h0);
      chk(rdata, {24'h0, e[7:0]});
      apb(1'b1, ADDR_MASK, 32'h0);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, ADDR_MASK, 32'h3);
      @(negedge clk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, ADDR_STATUS, 32'h3);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0);
    end
    go_sleep(SLP_IDLE);
    repeat (10) @(posedge clk);
    wake_other();
    wait_lvl(cpu_halted, 1'b0, n);
    chk({31'h0, woke}, 32'h0);
    wait_lvl(irq, 1'b1, n);
    chk_rng(n, 1, 40);
    apb(1'b1, ADDR_STATUS, 32'h3);
    repeat (60) @(posedge clk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rdata, 32'h80);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdata, 32'h0);
    go_sleep(3'h2);
    repeat (20) @(negedge clk);
    chk({30'h0, converter_on, conv_busy}, 32'h2);
    wake_other();
    wait_lvl(cpu_halted, 1'b0, n);
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h80);
    apb(1'b1, ADDR_MASK, 32'h1);
    conv(12'h800, 1'b1, 1'b1, 50);
    // Auto trigger armed: sleeping alone must not convert
    apb(1'b1, ADDR_CTRL, 32'ha0);
    go_sleep(SLP_NOISE);
    repeat (60) @(negedge clk);
    chk({31'h0, conv_busy}, 32'h0);
    @(posedge clk);
    trig <= 1'b1;
    wait_lvl(cpu_halted, 1'b0, n);
    @(posedge clk);
    trig <= 1'b0;
    chk({31'h0, woke}, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdata, 32'h1);
    report_and_stop();
  end
endmodule
